// file: rlh_cfg.svh
// constants for the route lookup entry state handler
`ifndef RLH_CFG_SVH
`define RLH_CFG_SVH
`define RLH_NUM_PORTS 16
`define RLH_PORT_W 4
`define RLH_DEST_W 10
`define RLH_TABLE_DEPTH 512
`define RLH_OOR_READ 4'hf
`define RLH_ZERO_PORT 4'h0
`define RLH_ZERO_HOP 8'h00
`define RLH_HOP_W 8
`define RLH_HDR_W 64
`endif

// file: rlh_pkg.sv
// types for the route lookup entry state handler
`include "rlh_cfg.svh"
package rlh_pkg;
    typedef enum logic [1:0] {
        RLH_ST_MAPPED,
        RLH_ST_DEFAULT,
        RLH_ST_DROP_DEFAULT,
        RLH_ST_DROP_PARITY
    } rlh_class_t;
endpackage

// file: rlh_tbl_if.sv
// carrier between the lookup core and the route table storage
`timescale 1ns/1ps
`include "rlh_cfg.svh"
interface rlh_tbl_if;
    logic wr_en;
    logic [`RLH_DEST_W-1:0] wr_addr;
    logic [`RLH_PORT_W-1:0] wr_port;
    logic [`RLH_DEST_W-1:0] rd_addr;
    logic [`RLH_PORT_W-1:0] rd_port;
    logic rd_par_ok;
    modport core (output wr_en, output wr_addr, output wr_port, output rd_addr,
                  input rd_port, input rd_par_ok);
    modport store (input wr_en, input wr_addr, input wr_port, input rd_addr,
                   output rd_port, output rd_par_ok);
endinterface

// file: rlh_table.sv
// route table storage with per-entry parity, not reset
`timescale 1ns/1ps
`include "rlh_cfg.svh"
module rlh_table
#(
    parameter int DEPTH = `RLH_TABLE_DEPTH
)
(
    input wire logic clk_i,
    rlh_tbl_if.store tbl
);
    // entries carry no reset; contents are unknown until written
    logic [`RLH_PORT_W:0] mem [DEPTH];
    logic [`RLH_PORT_W:0] rd_word;

    always_ff @(posedge clk_i)
    begin
        if (tbl.wr_en)
        begin
            // even parity kept beside the port value
            mem[tbl.wr_addr[$clog2(DEPTH)-1:0]] <= {^tbl.wr_port, tbl.wr_port};
        end
    end

    // random power-up contents give random lookups
    assign rd_word = mem[tbl.rd_addr[$clog2(DEPTH)-1:0]];
    assign tbl.rd_port = rd_word[`RLH_PORT_W-1:0];
    assign tbl.rd_par_ok = (^rd_word[`RLH_PORT_W-1:0]) == rd_word[`RLH_PORT_W];
endmodule

// file: rlh_route_lookup.sv
// route lookup entry state handler: one ingress port of the switch
`timescale 1ns/1ps
`include "rlh_cfg.svh"
module rlh_route_lookup
    import rlh_pkg::*;
#(
    parameter int NUM_PORTS = `RLH_NUM_PORTS,
    parameter int DEPTH = `RLH_TABLE_DEPTH,
    parameter logic [`RLH_PORT_W-1:0] THIS_PORT = `RLH_ZERO_PORT
)
(
    input wire logic clk_i,
    input wire logic resetn_i,
    // arriving packet
    input wire logic pkt_valid_i,
    input wire logic [`RLH_DEST_W-1:0] pkt_dest_i,
    input wire logic pkt_is_maint_i,
    input wire logic [`RLH_HOP_W-1:0] pkt_hop_i,
    input wire logic [`RLH_HDR_W-1:0] pkt_hdr_i,
    // default port setting
    input wire logic [`RLH_PORT_W-1:0] default_port_i,
    // standard table write path
    input wire logic std_wr_i,
    input wire logic [`RLH_DEST_W-1:0] std_dest_i,
    input wire logic [`RLH_PORT_W-1:0] std_port_i,
    // vendor table access path
    input wire logic vnd_wr_i,
    input wire logic vnd_rd_i,
    input wire logic [`RLH_DEST_W-1:0] vnd_dest_i,
    input wire logic [`RLH_PORT_W-1:0] vnd_port_i,
    // error flag clear
    input wire logic err_clr_i,
    // routing decision
    output logic route_valid_o,
    output logic [`RLH_PORT_W-1:0] route_port_o,
    output logic drop_o,
    output logic [1:0] entry_class_o,
    // error capture
    output logic impl_specific_error_flag_o,
    output logic route_table_parity_fault_o,
    output logic [`RLH_PORT_W-1:0] parity_port_o,
    output logic [`RLH_HDR_W-1:0] capture_hdr_o,
    output logic capture_valid_o,
    // vendor read answer
    output logic rd_valid_o,
    output logic [`RLH_PORT_W-1:0] rd_data_o
);
    // ==========================================================
    // parameter checks
    // ==========================================================
    if (NUM_PORTS < 1 || NUM_PORTS > (1 << `RLH_PORT_W))
    begin : g_bad_ports
        $error("port count does not fit the port field");
    end
    if (DEPTH < 2 || DEPTH > (1 << `RLH_DEST_W))
    begin : g_bad_depth
        $error("table depth does not fit the destination field");
    end
    if (int'(THIS_PORT) >= NUM_PORTS)
    begin : g_bad_this
        $error("arrival port is not a port of the switch");
    end

    // ==========================================================
    // reset release
    // ==========================================================
    logic rst_meta;
    logic rst_sync;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    wire rst_n = rst_sync;

    // ==========================================================
    // table writes and reads
    // ==========================================================
    rlh_tbl_if tbl ();

    logic std_in_range;
    logic vnd_in_range;
    logic lk_in_range;
    logic std_take;
    logic vnd_take;

    assign std_in_range = int'(std_dest_i) < DEPTH;
    assign vnd_in_range = int'(vnd_dest_i) < DEPTH;
    assign lk_in_range = int'(pkt_dest_i) < DEPTH;
    // writes past the table end are dropped here
    assign std_take = std_wr_i && std_in_range;
    assign vnd_take = vnd_wr_i && vnd_in_range;

    // standard path has priority if both write in one cycle
    always_comb
    begin
        tbl.wr_en = std_take || vnd_take;
        tbl.wr_addr = std_take ? std_dest_i : vnd_dest_i;
        tbl.wr_port = std_take ? std_port_i : vnd_port_i;
    end

    // the vendor read shares the lookup port only when no packet arrives
    // a read lost to a packet gets no answer; software must retry
    assign tbl.rd_addr = pkt_valid_i ? pkt_dest_i : vnd_dest_i;

    rlh_table #(
        .DEPTH(DEPTH)
    ) rlh_table_inst (
        .clk_i(clk_i),
        .tbl(tbl)
    );

    // ==========================================================
    // entry classification
    // ==========================================================
    logic entry_exists;
    logic default_exists;
    rlh_class_t next_class;
    logic [`RLH_PORT_W-1:0] next_port;

    // mapped means the named port exists in this switch
    assign entry_exists = int'(tbl.rd_port) < NUM_PORTS;
    assign default_exists = int'(default_port_i) < NUM_PORTS;

    always_comb
    begin
        next_port = tbl.rd_port;
        if (!lk_in_range || !tbl.rd_par_ok)
        begin
            // out-of-range lookup has no entry: treated like an unmapped one
            if (lk_in_range)
                next_class = RLH_ST_DROP_PARITY;
            else if (default_exists)
                next_class = RLH_ST_DEFAULT;
            else
                next_class = RLH_ST_DROP_DEFAULT;
            next_port = default_port_i;
        end
        else if (entry_exists)
        begin
            next_class = RLH_ST_MAPPED;
        end
        else if (default_exists)
        begin
            next_class = RLH_ST_DEFAULT;
            next_port = default_port_i;
        end
        else
        begin
            next_class = RLH_ST_DROP_DEFAULT;
            next_port = default_port_i;
        end
    end

    // zero-hop requests are answered here, whatever the entry says
    logic zero_hop;
    assign zero_hop = pkt_is_maint_i && (pkt_hop_i == `RLH_ZERO_HOP);

    logic next_drop;
    assign next_drop = (next_class == RLH_ST_DROP_PARITY) ||
                       (next_class == RLH_ST_DROP_DEFAULT);

    // ==========================================================
    // routing decision
    // ==========================================================
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            route_valid_o <= 1'b0;
            route_port_o <= `RLH_ZERO_PORT;
            drop_o <= 1'b0;
            entry_class_o <= RLH_ST_MAPPED;
        end
        else
        begin
            route_valid_o <= 1'b0;
            drop_o <= 1'b0;
            if (pkt_valid_i)
            begin
                // lookup done for every packet, maintenance included
                entry_class_o <= next_class;
                if (zero_hop)
                begin
                    route_valid_o <= 1'b1;
                    route_port_o <= THIS_PORT;
                end
                else if (next_drop)
                begin
                    drop_o <= 1'b1;
                end
                else
                begin
                    route_valid_o <= 1'b1;
                    route_port_o <= next_port;
                end
            end
        end
    end

    // ==========================================================
    // error capture
    // ==========================================================
    logic par_event;
    logic dflt_event;

    assign par_event = pkt_valid_i && (next_class == RLH_ST_DROP_PARITY);
    assign dflt_event = pkt_valid_i && !zero_hop && (next_class == RLH_ST_DROP_DEFAULT);

    // flags: a new event wins over a clear in the same cycle
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            impl_specific_error_flag_o <= 1'b0;
            route_table_parity_fault_o <= 1'b0;
        end
        else
        begin
            if (par_event || dflt_event)
                impl_specific_error_flag_o <= 1'b1;
            else if (err_clr_i)
                impl_specific_error_flag_o <= 1'b0;
            if (par_event)
                route_table_parity_fault_o <= 1'b1;
            else if (err_clr_i)
                route_table_parity_fault_o <= 1'b0;
        end
    end

    // capture holds the first error until cleared
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            capture_valid_o <= 1'b0;
            capture_hdr_o <= '0;
        end
        else if ((par_event || dflt_event) && (!capture_valid_o || err_clr_i))
        begin
            capture_valid_o <= 1'b1;
            capture_hdr_o <= pkt_hdr_i;
        end
        else if (err_clr_i)
        begin
            capture_valid_o <= 1'b0;
        end
    end

    // port record of every parity fault
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            parity_port_o <= `RLH_ZERO_PORT;
        end
        else if (par_event)
        begin
            parity_port_o <= THIS_PORT;
        end
    end

    // ==========================================================
    // vendor read answer
    // ==========================================================
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_valid_o <= 1'b0;
            rd_data_o <= `RLH_ZERO_PORT;
        end
        else
        begin
            rd_valid_o <= vnd_rd_i && !pkt_valid_i;
            if (vnd_rd_i && !pkt_valid_i)
                rd_data_o <= vnd_in_range ? tbl.rd_port : `RLH_OOR_READ;
        end
    end
endmodule

// file: rlh_route_lookup_props.sv
// concurrent checks on the ports of the route lookup entry state handler
`timescale 1ns/1ps
`include "rlh_cfg.svh"
module rlh_route_lookup_props
#(
    parameter int NUM_PORTS = 16,
    parameter int DEPTH = 512,
    parameter logic [`RLH_PORT_W-1:0] THIS_PORT = 4'h0
)
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic pkt_valid_i,
    input wire logic pkt_is_maint_i,
    input wire logic [`RLH_HOP_W-1:0] pkt_hop_i,
    input wire logic [`RLH_PORT_W-1:0] default_port_i,
    input wire logic vnd_rd_i,
    input wire logic [`RLH_DEST_W-1:0] vnd_dest_i,
    input wire logic err_clr_i,
    input wire logic route_valid_o,
    input wire logic [`RLH_PORT_W-1:0] route_port_o,
    input wire logic drop_o,
    input wire logic [1:0] entry_class_o,
    input wire logic impl_specific_error_flag_o,
    input wire logic route_table_parity_fault_o,
    input wire logic [`RLH_PORT_W-1:0] parity_port_o,
    input wire logic capture_valid_o,
    input wire logic rd_valid_o,
    input wire logic [`RLH_PORT_W-1:0] rd_data_o
);
    // ==========
    // properties
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    logic zero_hop;
    assign zero_hop = pkt_valid_i && pkt_is_maint_i && pkt_hop_i == 8'h00;
    AST_ONE_ANSWER: assert property (pkt_valid_i |=> route_valid_o ^ drop_o)
        else $error("packet got no single answer");
    AST_NO_SPURIOUS: assert property (!pkt_valid_i |=> !route_valid_o && !drop_o)
        else $error("decision without packet");
    AST_PORT_EXISTS: assert property (route_valid_o |-> route_port_o < NUM_PORTS)
        else $error("routed to missing port");
    AST_ZERO_HOP: assert property (zero_hop |=> route_valid_o && route_port_o == THIS_PORT)
        else $error("zero hop not answered on arrival port");
    AST_DEF_ROUTE: assert property (route_valid_o && entry_class_o == 2'h1
        && !$past(zero_hop) |-> route_port_o == $past(default_port_i))
        else $error("fallback not on default port");
    AST_DROP_FLAG: assert property (drop_o |-> impl_specific_error_flag_o && capture_valid_o)
        else $error("drop without flag and capture");
    AST_PAR_PORT: assert property (drop_o && entry_class_o == 2'h3
        |-> route_table_parity_fault_o && parity_port_o == THIS_PORT)
        else $error("parity drop without port record");
    AST_READ_OOR: assert property (vnd_rd_i && !pkt_valid_i && vnd_dest_i >= DEPTH
        |=> rd_valid_o && rd_data_o == 4'hf)
        else $error("out of range read not 0xf");
    AST_READ_ONLY: assert property (!(vnd_rd_i && !pkt_valid_i) |=> !rd_valid_o)
        else $error("read answer without read");
    AST_CLEAR: assert property (err_clr_i && !pkt_valid_i
        |=> !impl_specific_error_flag_o && !capture_valid_o)
        else $error("clear left flag or capture");
endmodule
bind rlh_route_lookup rlh_route_lookup_props #(.NUM_PORTS(NUM_PORTS), .DEPTH(DEPTH),
    .THIS_PORT(THIS_PORT)) rlh_route_lookup_props_inst (.clk_i(clk_i), .resetn_i(resetn_i),
    .pkt_valid_i(pkt_valid_i), .pkt_is_maint_i(pkt_is_maint_i), .pkt_hop_i(pkt_hop_i),
    .default_port_i(default_port_i), .vnd_rd_i(vnd_rd_i), .vnd_dest_i(vnd_dest_i),
    .err_clr_i(err_clr_i), .route_valid_o(route_valid_o), .route_port_o(route_port_o),
    .drop_o(drop_o), .entry_class_o(entry_class_o),
    .impl_specific_error_flag_o(impl_specific_error_flag_o),
    .route_table_parity_fault_o(route_table_parity_fault_o), .parity_port_o(parity_port_o),
    .capture_valid_o(capture_valid_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o));

// file: rlh_sw_model.sv
// configuring software model: programs every table entry after reset
`timescale 1ns/1ps
`include "rlh_cfg.svh"
module rlh_sw_model
(
    input wire logic clk_i,
    input wire logic start_i,
    output logic std_wr_o,
    output logic [`RLH_DEST_W-1:0] std_dest_o,
    output logic [`RLH_PORT_W-1:0] std_port_o,
    output logic done_o
);
    // ==========
    // programming sweep
    logic [10:0] cnt = 11'h000;
    initial std_wr_o = 1'b0;
    initial std_dest_o = 10'h000;
    initial std_port_o = 4'h0;
    assign done_o = cnt == 11'h200;
    always @(posedge clk_i)
    begin
        if (start_i && !done_o)
        begin
            std_wr_o <= 1'b1;
            std_dest_o <= cnt[9:0];
            std_port_o <= cnt[3:0];
            cnt <= cnt + 11'h001;
        end
        else
        begin
            std_wr_o <= 1'b0;
            std_port_o <= ~std_port_o; // stale data toggles when idle
        end
    end
endmodule

// file: route_lookup_entry_state_handler_test.sv
// self-checking testbench for the route lookup entry state handler
`timescale 1ns/1ps
`include "rlh_cfg.svh"
module route_lookup_entry_state_handler_test;
    // ==========
    // stimulus and design
    logic clk_i = 0, resetn_i = 0, pv = 0, pm = 0, vw = 0, vr = 0, clr = 0, go = 0, sw, done;
    logic [9:0] pd = 0, vd = 0, sd;
    logic [7:0] ph = 0;
    logic [63:0] hdr = 0;
    logic [3:0] dp = 4'h7, vp = 0, sp, rp, pp, rd;
    logic rv, dr, ef, pf, cv, rdv;
    logic [1:0] cls;
    logic [63:0] ch;
    int failures = 0, cmp_count = 0;
    initial forever #12.5 clk_i = ~clk_i;
    rlh_sw_model rlh_sw_model_inst (.clk_i(clk_i), .start_i(go), .std_wr_o(sw),
        .std_dest_o(sd), .std_port_o(sp), .done_o(done));
    rlh_route_lookup #(.NUM_PORTS(10), .THIS_PORT(4'h5)) rlh_route_lookup_inst (
        .clk_i(clk_i), .resetn_i(resetn_i), .pkt_valid_i(pv), .pkt_dest_i(pd),
        .pkt_is_maint_i(pm), .pkt_hop_i(ph), .pkt_hdr_i(hdr), .default_port_i(dp),
        .std_wr_i(sw), .std_dest_i(sd), .std_port_i(sp), .vnd_wr_i(vw), .vnd_rd_i(vr),
        .vnd_dest_i(vd), .vnd_port_i(vp), .err_clr_i(clr), .route_valid_o(rv),
        .route_port_o(rp), .drop_o(dr), .entry_class_o(cls),
        .impl_specific_error_flag_o(ef), .route_table_parity_fault_o(pf),
        .parity_port_o(pp), .capture_hdr_o(ch), .capture_valid_o(cv),
        .rd_valid_o(rdv), .rd_data_o(rd));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (failures == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // one packet; returns while its one-cycle answer stands
    task automatic send(input logic [9:0] d, input logic m, input logic [7:0] h);
        @(posedge clk_i);
        {pv, pd, pm, ph, hdr} <= {1'b1, d, m, h, 54'h0, d};
        @(posedge clk_i);
        pv <= 1'b0;
        #1;
    endtask
    // one vendor access; returns while a read answer stands
    task automatic vacc(input logic w, input logic [9:0] d, input logic [3:0] p);
        @(posedge clk_i);
        {vw, vr, vd, vp} <= {w, !w, d, p};
        @(posedge clk_i);
        {vw, vr} <= 2'b00;
        #1;
    endtask
    task automatic t_routes();
        send(10'h003, 0, 8'h01);
        check({rv, dr, rp, cls}, {2'b10, 4'h3, 2'h0});
        send(10'h00c, 0, 8'h01);
        check({rv, dr, rp, cls}, {2'b10, 4'h7, 2'h1});
        @(posedge clk_i);
        dp <= 4'hc;
        send(10'h00d, 0, 8'h01);
        check({rv, dr, cls, ef, cv}, {2'b01, 2'h2, 2'b11});
        check(ch, 64'h00d);
        send(10'h00e, 1, 8'h00);
        check({rv, dr, rp, cls}, {2'b10, 4'h5, 2'h2});
        send(10'h002, 1, 8'h01);
        check({rv, rp, pf, pp}, {1'b1, 4'h2, 1'b0, 4'h0});
    endtask
    task automatic t_capture();
        send(10'h01d, 0, 8'h01);
        check({dr, ef, cv}, 3'b111);
        send(10'h00b, 0, 8'h01);
        check({dr, ef, cv}, 3'b111);
        check(ch, 64'h01d);
        @(posedge clk_i);
        {pv, pd, pm, ph, hdr, clr} <= {1'b1, 10'h01e, 1'b0, 8'h01, 64'h01e, 1'b1};
        @(posedge clk_i);
        {pv, clr} <= 2'b00;
        #1;
        check({dr, ef, cv}, 3'b111);
        check(ch, 64'h01e);
    endtask
    task automatic t_vendor();
        vacc(1, 10'h014, 4'h1);
        send(10'h014, 0, 8'h01);
        check({rv, rp}, {1'b1, 4'h1});
        vacc(1, 10'h258, 4'h9);
        vacc(0, 10'h058, 4'h0);
        check({rdv, rd}, {1'b1, 4'h8});
        vacc(0, 10'h258, 4'h0);
        check({rdv, rd}, {1'b1, 4'hf});
        @(posedge clk_i);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        @(posedge clk_i);
        #1;
        check({ef, cv, pf}, 3'b000);
    endtask
    initial
    begin
        repeat (12) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        go <= 1'b1;
        while (!done) @(posedge clk_i);
        t_routes();
        t_vendor();
        t_capture();
        results();
    end
    initial
    begin
        #(25ns * 3000);
        failures++;
        results();
    end
endmodule
